// file: common/ipp_pkg.sv
// Package for the 24-line I/O-mapped parallel port: offsets, fields, types
package ipp_pkg;
    // I/O byte addresses of the eight locations; six are decoded, 8A/8B are not
    localparam logic [7:0] LOW_A_DATA_ADDR = 8'h80;
    localparam logic [7:0] LOW_A_CTRL_ADDR = 8'h81;
    localparam logic [7:0] LOW_B_DATA_ADDR = 8'h82;
    localparam logic [7:0] LOW_B_CTRL_ADDR = 8'h83;
    localparam logic [7:0] HIGH_A_DATA_ADDR = 8'h88;
    localparam logic [7:0] HIGH_A_CTRL_ADDR = 8'h89;
    localparam logic [7:0] HIGH_B_DATA_UNUSED_ADDR = 8'h8A;
    localparam logic [7:0] HIGH_B_CTRL_UNUSED_ADDR = 8'h8B;
    // Field position: control bit that selects data over direction
    localparam int CTRL_DATA_SEL_BIT = 2;
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] OUT_RESET = 8'hFF;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    // Answer on a read that hits no decoded location
    localparam logic [7:0] UNMAPPED_READ = 8'hFF;
    // Port count and lines per port
    localparam int NUM_PORTS = 3;
    localparam int PORT_WIDTH = 8;
    localparam int NUM_LINES = NUM_PORTS * PORT_WIDTH;

    // One I/O-space bus request from the host
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic io_wr;
        logic io_rd;
    } ipp_io_req_t;

    // Pin group for the 24 lines
    typedef struct packed {
        logic [NUM_LINES-1:0] level;
        logic [NUM_LINES-1:0] enable;
    } ipp_pins_t;
endpackage : ipp_pkg

// file: src/ipp_parallel_port.sv
// Top module: 24-line I/O-mapped parallel port with three 8-bit ports
//
// Behaviour
// - 24 lines, each senses or drives
// - Lower adapter: ports A,B at 80-83
// - Upper adapter: port A at 88-89
// - Upper port B absent, 8A/8B undefined
// - No handshake or interrupt lines exposed
// - Decode data/control for each port
// - Control cleared: data address sets direction
// - Direction held per line
// - Data read gives lines, write drives
// - Registers in I/O space, not memory
// - Output lines active low at modules
//
// Port 0 is lower adapter port A (lines 7:0), port 1 its port B (lines 15:8),
// port 2 upper adapter port A (lines 23:16); upper port B has no lines at all.
// Control bit 2 steers each data location to the direction byte or to the latch.
// Writes act at the strobe edge; the read answer is registered and stands until
// the next read strobe, so the host takes it one cycle after its read.
// Limitation: an output bit reads back its latch, not its pin, so a line pulled
// against its driver outside is not seen; this keeps reads free of pin noise.
// Trade-off: control keeps the whole byte although only bit 2 acts here.
`timescale 1ns/10ps
module ipp_parallel_port (
    input wire logic clock,
    input wire logic arst_n,
    input wire ipp_pkg::ipp_io_req_t io_req,
    output logic [7:0] io_rdata,
    input wire logic [ipp_pkg::NUM_LINES-1:0] line_in,
    output logic [ipp_pkg::NUM_LINES-1:0] line_out,
    output logic [ipp_pkg::NUM_LINES-1:0] line_oe
);
    localparam int NP = ipp_pkg::NUM_PORTS;
    localparam int W = ipp_pkg::PORT_WIDTH;

    // Data address of port p (0 low A, 1 low B, 2 high A)
    function automatic logic [7:0] data_addr(input int p);
        case (p)
            0: data_addr = ipp_pkg::LOW_A_DATA_ADDR;
            1: data_addr = ipp_pkg::LOW_B_DATA_ADDR;
            default: data_addr = ipp_pkg::HIGH_A_DATA_ADDR;
        endcase
    endfunction

    // Control address of port p
    function automatic logic [7:0] ctrl_addr(input int p);
        case (p)
            0: ctrl_addr = ipp_pkg::LOW_A_CTRL_ADDR;
            1: ctrl_addr = ipp_pkg::LOW_B_CTRL_ADDR;
            default: ctrl_addr = ipp_pkg::HIGH_A_CTRL_ADDR;
        endcase
    endfunction

    // Per-port register state
    logic [W-1:0] ctrl_reg [NP];
    logic [W-1:0] dir_reg [NP];
    logic [W-1:0] out_reg [NP];
    // Per-port read candidates and hits
    logic [W-1:0] port_rdata [NP];
    logic [NP-1:0] rd_hit;
    logic [7:0] rdata_next;

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            // Decode of this port's two locations
            wire hit_data = (io_req.addr == data_addr(p));
            wire hit_ctrl = (io_req.addr == ctrl_addr(p));
            wire sel_data = ctrl_reg[p][ipp_pkg::CTRL_DATA_SEL_BIT];
            wire wr_ctrl = io_req.io_wr && hit_ctrl;
            wire wr_dir = io_req.io_wr && hit_data && !sel_data;
            wire wr_out = io_req.io_wr && hit_data && sel_data;
            // Lines read back: driven lines show the latch, inputs the pin
            wire [W-1:0] line_state =
                (dir_reg[p] & out_reg[p]) | (~dir_reg[p] & line_in[p*W +: W]);

            // Control and direction registers, cleared on reset
            // Reset clears configuration
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    ctrl_reg[p] <= ipp_pkg::CTRL_RESET;
                    dir_reg[p] <= ipp_pkg::DIR_RESET;
                end else begin
                    // Control takes any byte; only bit 2 has an effect here
                    if (wr_ctrl) begin
                        ctrl_reg[p] <= io_req.wdata;
                    end
                    if (wr_dir) begin
                        dir_reg[p] <= io_req.wdata;
                    end
                end
            end

            // Output latch; resets high so modules start off
            // High level means module off
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    out_reg[p] <= ipp_pkg::OUT_RESET;
                end else if (wr_out) begin
                    out_reg[p] <= io_req.wdata;
                end
            end

            // Read mux for this port
            assign port_rdata[p] = hit_ctrl ? ctrl_reg[p] :
                                   (sel_data ? line_state : dir_reg[p]);
            assign rd_hit[p] = hit_data || hit_ctrl;

            // Each line drives when its direction bit is set
            assign line_out[p*W +: W] = out_reg[p];
            assign line_oe[p*W +: W] = dir_reg[p];
        end
    endgenerate

    // Read data select; 8A/8B and other addresses answer a fixed value
    // Upper port B unmapped
    always_comb begin
        // A miss answers the fixed value; a real hit overrides it
        rdata_next = ipp_pkg::UNMAPPED_READ;
        // Port locations are disjoint, so at most one hit is ever set
        for (int i = 0; i < NP; i++) begin
            if (rd_hit[i]) begin
                rdata_next = port_rdata[i];
            end
        end
    end

    // Registered read answer, valid the cycle after an I/O read strobe
    // Read on I/O read cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            // Reset answer
            io_rdata <= ipp_pkg::RDATA_RESET;
        end else if (io_req.io_rd) begin
            // Only a read strobe updates it, so the answer stands between reads
            io_rdata <= rdata_next;
        end
    end

    // No handshake or interrupt ports exist on this module
    // The adapters' strobe and interrupt pins stay open, so nothing drives them
    // and no event here can raise a request toward the host

    // Assertions: all but reset_clear_a watch outputs or ctrl_reg one cycle after the
    // strobe edge, since writes land at that edge and the read answer is registered.
    // The generate body is shared by all ports, so each check picks the port
    // where the scenario exercises that path.

    reset_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
        $rose(arst_n) |-> line_oe == {ipp_pkg::NUM_PORTS{ipp_pkg::DIR_RESET}}
            && line_out == {ipp_pkg::NUM_PORTS{ipp_pkg::OUT_RESET}}
            && io_rdata == ipp_pkg::RDATA_RESET)
        else $error("state not clean after reset");

    dir_write_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_wr && io_req.addr == ipp_pkg::LOW_A_DATA_ADDR && !ctrl_reg[0][2])
        |=> line_oe[7:0] == $past(io_req.wdata))
        else $error("low A direction not taken");

    low_b_dir_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_wr && io_req.addr == ipp_pkg::LOW_B_DATA_ADDR && !ctrl_reg[1][2])
        |=> line_oe[15:8] == $past(io_req.wdata))
        else $error("low B direction not taken");

    high_dir_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_wr && io_req.addr == ipp_pkg::HIGH_A_DATA_ADDR && !ctrl_reg[2][2])
        |=> line_oe[23:16] == $past(io_req.wdata))
        else $error("high A direction not taken");

    out_write_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_wr && io_req.addr == ipp_pkg::LOW_B_DATA_ADDR && ctrl_reg[1][2])
        |=> line_out[15:8] == $past(io_req.wdata))
        else $error("low B output not taken");

    high_out_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_wr && io_req.addr == ipp_pkg::HIGH_A_DATA_ADDR && ctrl_reg[2][2])
        |=> line_out[23:16] == $past(io_req.wdata))
        else $error("high A output not taken");

    dir_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_wr && io_req.addr == ipp_pkg::HIGH_A_DATA_ADDR && ctrl_reg[2][2])
        |=> $stable(line_oe[23:16]))
        else $error("high A direction changed in data mode");

    low_b_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_wr && io_req.addr == ipp_pkg::LOW_B_DATA_ADDR && ctrl_reg[1][2])
        |=> $stable(line_oe[15:8]))
        else $error("low B direction changed in data mode");

    out_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_wr && io_req.addr == ipp_pkg::LOW_A_DATA_ADDR && !ctrl_reg[0][2])
        |=> $stable(line_out[7:0]))
        else $error("low A output changed in direction mode");

    high_out_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_wr && io_req.addr == ipp_pkg::HIGH_A_DATA_ADDR && !ctrl_reg[2][2])
        |=> $stable(line_out[23:16]))
        else $error("high A output changed in direction mode");

    // Control takes whole byte
    // Only bit 2 acts, but the host reads the full byte back
    ctrl_write_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_wr && io_req.addr == ipp_pkg::LOW_B_CTRL_ADDR)
        |=> ctrl_reg[1] == $past(io_req.wdata))
        else $error("low B control not taken");

    ctrl_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_rd && io_req.addr == ipp_pkg::HIGH_A_CTRL_ADDR)
        |=> io_rdata == $past(ctrl_reg[2]))
        else $error("control readback wrong");

    dir_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_rd && io_req.addr == ipp_pkg::LOW_A_DATA_ADDR && !ctrl_reg[0][2])
        |=> io_rdata == $past(line_oe[7:0]))
        else $error("low A direction read wrong");

    input_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_rd && io_req.addr == ipp_pkg::LOW_A_DATA_ADDR && ctrl_reg[0][2]
         && line_oe[0] == 1'b0)
        |=> io_rdata[0] == $past(line_in[0]))
        else $error("input line not read back");

    // Mixed lines read back
    // Driven bits show the latch, the others the pin
    data_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_rd && io_req.addr == ipp_pkg::LOW_B_DATA_ADDR && ctrl_reg[1][2])
        |=> io_rdata == $past((line_oe[15:8] & line_out[15:8])
            | (~line_oe[15:8] & line_in[15:8])))
        else $error("low B line read wrong");

    // Read answer stands
    // The host may take the byte late, so it must hold between reads
    rdata_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        !io_req.io_rd |=> $stable(io_rdata))
        else $error("read answer changed without read");

    unused_read_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_rd && io_req.addr == ipp_pkg::HIGH_B_DATA_UNUSED_ADDR)
        |=> io_rdata == ipp_pkg::UNMAPPED_READ)
        else $error("unused location read not fixed");

    unused_ctrl_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_rd && io_req.addr == ipp_pkg::HIGH_B_CTRL_UNUSED_ADDR)
        |=> io_rdata == ipp_pkg::UNMAPPED_READ)
        else $error("unused control read not fixed");

    no_strobe_a: assert property (@(posedge clock) disable iff (!arst_n)
        !io_req.io_wr |=> $stable(line_oe) && $stable(line_out))
        else $error("lines changed without write");

    unused_write_a: assert property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_wr && (io_req.addr == ipp_pkg::HIGH_B_DATA_UNUSED_ADDR
            || io_req.addr == ipp_pkg::HIGH_B_CTRL_UNUSED_ADDR))
        |=> $stable(line_oe) && $stable(line_out))
        else $error("unused write changed state");

    // Main scenarios
    // Full three-step set-up of low A
    init_seq_c: cover property (@(posedge clock) disable iff (!arst_n)
        (io_req.io_wr && io_req.addr == ipp_pkg::LOW_A_CTRL_ADDR && io_req.wdata == 8'h00)
        ##1 (io_req.io_wr && io_req.addr == ipp_pkg::LOW_A_DATA_ADDR)
        ##1 (io_req.io_wr && io_req.addr == ipp_pkg::LOW_A_CTRL_ADDR
             && io_req.wdata == 8'h34));
    // Two lowest lines driven and on
    drive_c: cover property (@(posedge clock) disable iff (!arst_n)
        line_oe[1:0] == 2'h3 && line_out[1:0] == 2'h0);
    // Data read of the upper adapter
    high_read_c: cover property (@(posedge clock) disable iff (!arst_n)
        io_req.io_rd && io_req.addr == ipp_pkg::HIGH_A_DATA_ADDR && ctrl_reg[2][2]);
    // Mixed directions within one port
    dir_mix_c: cover property (@(posedge clock) disable iff (!arst_n)
        line_oe[7:0] == 8'hF0);
    // Read of the unused control location
    unused_ctrl_c: cover property (@(posedge clock) disable iff (!arst_n)
        io_req.io_rd && io_req.addr == ipp_pkg::HIGH_B_CTRL_UNUSED_ADDR);
endmodule // ipp_parallel_port

// file: verification/ipp_host_model.sv
// Host processor model: issues I/O-space byte writes and reads to the port
`timescale 1ns/10ps
module ipp_host_model (
    input wire logic clock,
    input wire logic [7:0] io_rdata,
    output ipp_pkg::ipp_io_req_t io_req
);
    // Bus starts idle
    initial begin
        io_req = '{addr: 8'h00, wdata: 8'h00, io_wr: 1'b0, io_rd: 1'b0};
    end
    // I/O write cycle
    // Strobe is left high so a following call never assigns it twice in one step
    task automatic io_write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        io_req = '{addr: addr, wdata: data, io_wr: 1'b1, io_rd: 1'b0};
    endtask
    // I/O read cycle, answer taken half a cycle after the strobe edge
    task automatic io_read(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clock);
        io_req = '{addr: addr, wdata: ~io_req.wdata, io_wr: 1'b0, io_rd: 1'b1};
        @(negedge clock);
        io_req = '{addr: ~addr, wdata: ~io_req.wdata, io_wr: 1'b0, io_rd: 1'b0};
        data = io_rdata;
    endtask
    // Released bus: strobes low, address and data flipped so stale values never pass
    task automatic idle();
        @(negedge clock);
        io_req = '{addr: ~io_req.addr, wdata: ~io_req.wdata, io_wr: 1'b0, io_rd: 1'b0};
    endtask
    task automatic port_init(input logic [7:0] ctrl, input logic [7:0] data,
        input logic [7:0] dir);
        io_write(ctrl, 8'h00);
        io_write(data, dir);
        io_write(ctrl, 8'h34);
        idle();
    endtask
endmodule // ipp_host_model

// file: verification/test_ipp_parallel_port.sv
// Self-checking testbench for the 24-line parallel port
`timescale 1ns/10ps
module test_ipp_parallel_port;
    logic clock;
    logic arst_n;
    ipp_pkg::ipp_io_req_t io_req;
    logic [7:0] io_rdata;
    logic [23:0] line_in;
    logic [23:0] line_out;
    logic [23:0] line_oe;
    logic [23:0] pattern_in;
    logic [23:0] exp_oe;
    logic [23:0] exp_out;
    logic [7:0] rd;
    int miscompares;
    int compares;
    // Data and control address of each port, lowest lines first
    logic [7:0] data_addr [3] = '{ipp_pkg::LOW_A_DATA_ADDR, ipp_pkg::LOW_B_DATA_ADDR,
        ipp_pkg::HIGH_A_DATA_ADDR};
    logic [7:0] ctrl_addr [3] = '{ipp_pkg::LOW_A_CTRL_ADDR, ipp_pkg::LOW_B_CTRL_ADDR,
        ipp_pkg::HIGH_A_CTRL_ADDR};
    // Rack model: driven lines read back their latch, inputs follow a fixed pattern
    assign line_in = (line_oe & line_out) | (~line_oe & pattern_in);
    ipp_parallel_port ipp_parallel_port_inst (.clock(clock), .arst_n(arst_n), .io_req(io_req),
        .io_rdata(io_rdata), .line_in(line_in), .line_out(line_out), .line_oe(line_oe));
    ipp_host_model ipp_host_model_inst (.clock(clock), .io_rdata(io_rdata), .io_req(io_req));
    // Free-running 50 MHz clock
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Compare and count
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Lines idle as inputs with latches off, direction reads zero
    task automatic check_reset();
        chk("line_oe", line_oe, 24'h000000);
        chk("line_out", line_out, 24'hFFFFFF);
        for (int p = 0; p < 3; p++) begin
            ipp_host_model_inst.io_read(data_addr[p], rd);
            chk("dir reset", {16'h0000, rd}, 24'h000000);
        end
    endtask
    // Each port: mixed direction, active-low drive, read of mixed lines
    task automatic init_ports();
        for (int p = 0; p < 3; p++) begin
            ipp_host_model_inst.port_init(ctrl_addr[p], data_addr[p], 8'h03 << p);
            exp_oe[p*8+:8] = 8'h03 << p;
            chk("line_oe", line_oe, exp_oe);
            ipp_host_model_inst.io_read(ctrl_addr[p], rd);
            chk("ctrl", {16'h0000, rd}, 24'h000034);
            ipp_host_model_inst.io_write(data_addr[p], 8'hFC);
            ipp_host_model_inst.idle();
            exp_out[p*8+:8] = 8'hFC;
            chk("line_out", line_out, exp_out);
            ipp_host_model_inst.io_read(data_addr[p], rd);
            chk("data", {16'h0000, rd},
                {16'h0000, (8'hFC & exp_oe[p*8+:8]) | (pattern_in[p*8+:8] & ~exp_oe[p*8+:8])});
        end
    endtask
    // Unused and undecoded places change nothing and read FF
    task automatic check_unmapped();
        logic [7:0] bad [4] = '{8'h8A, 8'h8B, 8'h84, 8'h7F};
        for (int i = 0; i < 4; i++) begin
            ipp_host_model_inst.io_write(bad[i], 8'h00);
            ipp_host_model_inst.idle();
            chk("oe kept", line_oe, exp_oe);
            chk("out kept", line_out, exp_out);
            ipp_host_model_inst.io_read(bad[i], rd);
            chk("unmapped", {16'h0000, rd}, 24'h0000FF);
        end
    endtask
    // Cleared control bit 2 turns the data address back to direction
    task automatic check_dir_select();
        ipp_host_model_inst.io_write(ctrl_addr[0], 8'h00);
        ipp_host_model_inst.io_read(data_addr[0], rd);
        chk("dir read", {16'h0000, rd}, 24'h000003);
        ipp_host_model_inst.io_write(data_addr[0], 8'hF0);
        ipp_host_model_inst.io_write(ctrl_addr[0], 8'h34);
        ipp_host_model_inst.io_write(data_addr[0], 8'hC3);
        ipp_host_model_inst.idle();
        exp_oe[7:0] = 8'hF0;
        exp_out[7:0] = 8'hC3;
        chk("oe per line", line_oe, exp_oe);
        chk("out per line", line_out, exp_out);
        // Driven upper nibble shows the latch, lower nibble the rack pattern
        ipp_host_model_inst.io_read(data_addr[0], rd);
        chk("mixed read", {16'h0000, rd}, {16'h0000, 8'hC0 | (pattern_in[7:0] & 8'h0F)});
    endtask
    // Verdict and end of run
    task automatic end_of_test();
        if (miscompares == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdog so a stuck run still reaches the verdict
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        end_of_test();
    end
    // Main sequence
    initial begin
        arst_n = 1'b0;
        pattern_in = 24'hA5C35A;
        exp_oe = 24'h000000;
        exp_out = 24'hFFFFFF;
        miscompares = 0;
        compares = 0;
        repeat (3) @(negedge clock);
        arst_n = 1'b1;
        check_reset();
        init_ports();
        check_unmapped();
        check_dir_select();
        end_of_test();
    end
endmodule // test_ipp_parallel_port
